/* File: hdl/dag_params.svh */
/*
 * constants for data address generation: special function map of the
 * pointer pairs and their operand registers, access bank split, reset values.
 * assumes: 12-bit linear data space, pointer groups stacked downward.
 */
`ifndef DAG_PARAMS_SVH
`define DAG_PARAMS_SVH

// operand register block of pair n sits at DAG_VIRT_TOP0 - n * DAG_PAIR_STRIDE
`define DAG_VIRT_TOP0     12'hFEF
`define DAG_PAIR_STRIDE   12'h008
`define DAG_IND_ONE       12'hFE7
// distance below the block top: plain, post-inc, post-dec, pre-inc, offset, high, low
`define DAG_OFS_PLAIN     12'h000
`define DAG_OFS_LOW       12'h006
`define DAG_PAIR_COUNT    3

`define DAG_ACCESS_SPLIT  8'h80
`define DAG_ACCESS_HI     4'hF
`define DAG_ACCESS_LO     4'h0
`define DAG_EXT_LIMIT     8'h5F

`define DAG_PTR_RESET     12'h000
`define DAG_PTR_STEP      12'h001
`define DAG_HIGH_PAD      4'h0

`endif

/* File: hdl/dag_pkg.sv */
/*
 * types for data address generation: request, result, pointer control.
 * assumes: dag_params.svh supplies the numbers.
 */
package dag_pkg;

    typedef enum logic [1:0] {DAG_INHERENT, DAG_LITERAL, DAG_DIRECT, DAG_FULL_MOVE} dag_mode_t;

    // order matters: kind = distance below the block top plus one
    typedef enum logic [2:0] {V_NONE, V_PLAIN, V_POST_INCREMENT_OPERAND, V_POST_DECREMENT_OPERAND, V_PRE_INCREMENT_OPERAND, V_OFFSET_BY_WORKING_OPERAND, V_HIGH, V_LOW} dag_kind_t;

    typedef struct packed {
        dag_kind_t   kind;
        logic [1:0]  pair;
    } dag_hit_t;

    typedef struct packed {
        dag_mode_t   mode;
        logic [7:0]  fileAddr;
        logic        accessSel;
        logic        destSel;
        logic [11:0] fullSrc;
        logic [11:0] fullDst;
        logic [19:0] literal;
        logic [7:0]  wrData;
    } dag_req_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] srcAddr;
        logic [11:0] dstAddr;
        logic        memRd;
        logic        memWr;
        logic        readZero;
        logic        toWork;
        logic        ptrHit;
        logic [7:0]  ptrData;
        logic [19:0] progTarget;
        logic [7:0]  literal;
    } dag_res_t;

    typedef struct packed {
        logic        inc;
        logic        dec;
        logic        loadHi;
        logic        loadLo;
        logic [7:0]  data;
    } dag_ptr_ctl_t;

    typedef struct packed {
        logic [11:0] ptr;
    } dag_ptr_state_t;

    typedef struct packed {
        dag_res_t    res;
    } dag_state_t;

endpackage

/* File: hdl/dag_ptr_unit.sv */
/*
 * one 12-bit pointer pair with low byte and high nibble loads and whole-pair step.
 * assumes: at most one of inc/dec per cycle; a load wins over a step.
 */
`timescale 1ns/100ps
`include "dag_params.svh"

module dag_ptr_unit import dag_pkg::*; (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire dag_ptr_ctl_t  ctl,
    output      logic [11:0]   ptr
);

    dag_ptr_state_t st_ff;
    dag_ptr_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (ctl.loadHi) begin
            nxt_st.ptr[11:8] = ctl.data[3:0];
        end else if (ctl.loadLo) begin
            nxt_st.ptr[7:0] = ctl.data;
        end else if (ctl.inc) begin
            nxt_st.ptr = st_ff.ptr + `DAG_PTR_STEP;
        end else if (ctl.dec) begin
            nxt_st.ptr = st_ff.ptr - `DAG_PTR_STEP;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '{ptr: `DAG_PTR_RESET};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ptr = st_ff.ptr;

    ptr_step_a: assert property (@(posedge clock) disable iff (rst)
        ctl.inc && !ctl.loadHi && !ctl.loadLo |=> ptr == $past(ptr) + `DAG_PTR_STEP)
        else $error("pointer step lost carry");

    hi_nibble_a: assert property (@(posedge clock) disable iff (rst)
        ctl.loadHi |=> ptr[11:8] == $past(ctl.data[3:0]) && ptr[7:0] == $past(ptr[7:0]))
        else $error("high byte load wrong");

endmodule

/* File: hdl/dag_top.sv */
/*
 * data address generation: resolves direct, indirect and full-address operands,
 * steps the three pointer pairs, picks the result destination.
 * assumes: one request per cycle from the decoder, wrData already holds the result
 * to be written, memory and other special registers answer the registered outputs.
 */
`timescale 1ns/100ps
`include "dag_params.svh"

module dag_top import dag_pkg::*; (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        reqValid,
    input  wire dag_req_t    req,
    input  wire logic [3:0]  bankSel,
    input  wire logic [7:0]  workReg,
    input  wire logic        extendedSet,
    output      dag_res_t    res,
    output      logic [11:0] ptrZero,
    output      logic [11:0] ptrOne,
    output      logic [11:0] ptrTwo
);

    dag_state_t    st_ff;
    dag_state_t    nxt_st;
    dag_ptr_ctl_t  ctl [`DAG_PAIR_COUNT];
    logic [11:0]   ptrs [`DAG_PAIR_COUNT];
    logic [3:0]    accessTop;
    logic          indexedLit;
    logic [11:0]   firstAddr;
    dag_hit_t      firstHit;
    logic [11:0]   selPtr;
    logic [11:0]   target;
    dag_hit_t      tgtHit;
    logic          ownLoad;
    logic          physAccess;
    dag_hit_t      physHit;

    function automatic logic isVirt(input dag_kind_t k);
        return k != V_NONE && k != V_HIGH && k != V_LOW;
    endfunction

    function automatic logic isPtrReg(input dag_kind_t k);
        return k == V_HIGH || k == V_LOW;
    endfunction

    // maps an address onto a pair's operand or pointer register, if any
    function automatic dag_hit_t virtHit(input logic [11:0] a);
        dag_hit_t    h;
        logic [11:0] base;
        logic [11:0] off;
        h = '{kind: V_NONE, pair: 2'h0};
        for (int n = 0; n < `DAG_PAIR_COUNT; n++) begin
            base = `DAG_VIRT_TOP0 - 12'(n) * `DAG_PAIR_STRIDE;
            off  = base - a;
            if (off <= `DAG_OFS_LOW) begin
                h.kind = dag_kind_t'(off[2:0] + 3'h1);
                h.pair = 2'(n);
            end
        end
        return h;
    endfunction

    genvar g;
    generate
        for (g = 0; g < `DAG_PAIR_COUNT; g++) begin : gPair
            dag_ptr_unit uPtr (
                .clock (clock),
                .rst   (rst),
                .ctl   (ctl[g]),
                .ptr   (ptrs[g])
            );
        end
    endgenerate

    assign ptrZero = ptrs[0];
    assign ptrOne  = ptrs[1];
    assign ptrTwo  = ptrs[2];

    // first-level operand address
    assign accessTop  = (req.fileAddr >= `DAG_ACCESS_SPLIT) ? `DAG_ACCESS_HI : `DAG_ACCESS_LO;
    assign indexedLit = extendedSet && !req.accessSel && req.fileAddr <= `DAG_EXT_LIMIT;

    always_comb begin
        if (req.accessSel) begin
            firstAddr = {bankSel, req.fileAddr};
        end else if (indexedLit) begin
            firstAddr = ptrs[2] + {4'h0, req.fileAddr};
        end else begin
            firstAddr = {accessTop, req.fileAddr};
        end
    end

    assign firstHit = virtHit(firstAddr);
    assign selPtr   = ptrs[firstHit.pair];

    // second level: bank and access bit play no part here
    always_comb begin
        case (firstHit.kind)
            V_PRE_INCREMENT_OPERAND: target = selPtr + `DAG_PTR_STEP;
            V_OFFSET_BY_WORKING_OPERAND:  target = selPtr + {{4{workReg[7]}}, workReg};
            default:  target = selPtr;
        endcase
    end

    assign tgtHit  = virtHit(target);
    assign ownLoad = req.destSel && isPtrReg(tgtHit.kind) && tgtHit.pair == firstHit.pair;

    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < `DAG_PAIR_COUNT; i++) begin
            ctl[i] = '0;
        end
        physAccess            = 1'b0;
        physHit               = firstHit;
        nxt_st.res.valid      = reqValid;
        nxt_st.res.memRd      = 1'b0;
        nxt_st.res.memWr      = 1'b0;
        nxt_st.res.readZero   = 1'b0;
        nxt_st.res.ptrHit     = 1'b0;
        if (reqValid) begin
            case (req.mode)
                DAG_LITERAL: begin
                    nxt_st.res.literal    = req.literal[7:0];
                    nxt_st.res.progTarget = req.literal;
                end
                DAG_FULL_MOVE: begin
                    nxt_st.res.srcAddr = req.fullSrc;
                    nxt_st.res.dstAddr = req.fullDst;
                    nxt_st.res.memRd   = 1'b1;
                    nxt_st.res.memWr   = 1'b1;
                    nxt_st.res.toWork  = 1'b0;
                end
                DAG_DIRECT: begin
                    nxt_st.res.toWork = ~req.destSel;
                    if (isVirt(firstHit.kind)) begin
                        if (isVirt(tgtHit.kind)) begin
                            // no second indirection: reads give zero, writes and steps are dropped
                            nxt_st.res.readZero = 1'b1;
                        end else begin
                            nxt_st.res.srcAddr = target;
                            nxt_st.res.dstAddr = target;
                            nxt_st.res.memRd   = 1'b1;
                            nxt_st.res.memWr   = req.destSel;
                            physAccess         = 1'b1;
                            physHit            = tgtHit;
                            // steps bypass the alu, so no status flag ever moves
                            if (!ownLoad) begin
                                ctl[firstHit.pair].inc = firstHit.kind == V_POST_INCREMENT_OPERAND
                                                      || firstHit.kind == V_PRE_INCREMENT_OPERAND;
                                ctl[firstHit.pair].dec = firstHit.kind == V_POST_DECREMENT_OPERAND;
                            end
                        end
                    end else begin
                        nxt_st.res.srcAddr = firstAddr;
                        nxt_st.res.dstAddr = firstAddr;
                        nxt_st.res.memRd   = 1'b1;
                        nxt_st.res.memWr   = req.destSel;
                        physAccess         = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // pointer bytes live here; memory side ignores this address
        if (physAccess && isPtrReg(physHit.kind)) begin
            nxt_st.res.ptrHit  = 1'b1;
            nxt_st.res.ptrData = (physHit.kind == V_HIGH) ? {`DAG_HIGH_PAD, ptrs[physHit.pair][11:8]}
                                                         : ptrs[physHit.pair][7:0];
            ctl[physHit.pair].loadHi = req.destSel && physHit.kind == V_HIGH;
            ctl[physHit.pair].loadLo = req.destSel && physHit.kind == V_LOW;
            ctl[physHit.pair].data   = req.wrData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign res = st_ff.res;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    direct_bank_a: assert property (
        reqValid && req.mode == DAG_DIRECT && req.accessSel && bankSel != `DAG_ACCESS_HI
        |=> res.srcAddr == {$past(bankSel), $past(req.fileAddr)} && res.memRd)
        else $error("banked direct address wrong");

    access_low_a: assert property (
        reqValid && req.mode == DAG_DIRECT && !req.accessSel && !extendedSet
        && req.fileAddr < `DAG_ACCESS_SPLIT
        |=> res.srcAddr == {`DAG_ACCESS_LO, $past(req.fileAddr)})
        else $error("access bank address wrong");

    full_move_a: assert property (
        reqValid && req.mode == DAG_FULL_MOVE
        |=> res.srcAddr == $past(req.fullSrc) && res.dstAddr == $past(req.fullDst) && res.memWr)
        else $error("full move addresses wrong");

    dest_select_a: assert property (
        reqValid && req.mode == DAG_DIRECT && !isVirt(firstHit.kind)
        |=> res.toWork == !$past(req.destSel) && res.memWr == $past(req.destSel))
        else $error("destination select wrong");

    post_inc_a: assert property (
        reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_POST_INCREMENT_OPERAND
        && !isVirt(tgtHit.kind) && !isPtrReg(tgtHit.kind)
        |=> res.srcAddr == $past(selPtr) && ptrs[$past(firstHit.pair)] == $past(selPtr) + `DAG_PTR_STEP)
        else $error("post increment wrong");

    post_dec_a: assert property (
        reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_POST_DECREMENT_OPERAND
        && !isVirt(tgtHit.kind) && !isPtrReg(tgtHit.kind)
        |=> res.srcAddr == $past(selPtr) && ptrs[$past(firstHit.pair)] == $past(selPtr) - `DAG_PTR_STEP)
        else $error("post decrement wrong");

    pre_inc_a: assert property (
        reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_PRE_INCREMENT_OPERAND
        && !isVirt(tgtHit.kind) && !isPtrReg(tgtHit.kind)
        |=> res.srcAddr == $past(selPtr) + `DAG_PTR_STEP && ptrs[$past(firstHit.pair)] == res.srcAddr)
        else $error("pre increment wrong");

    offset_hold_a: assert property (
        reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_OFFSET_BY_WORKING_OPERAND
        && !isVirt(tgtHit.kind) && !isPtrReg(tgtHit.kind)
        |=> res.srcAddr == $past(selPtr) + {{4{$past(workReg[7])}}, $past(workReg)}
        && ptrs[$past(firstHit.pair)] == $past(selPtr))
        else $error("offset operand wrong");

    virt_zero_a: assert property (
        reqValid && req.mode == DAG_DIRECT && isVirt(firstHit.kind) && isVirt(tgtHit.kind)
        |=> res.readZero && !res.memRd ##1 !res.readZero || $past(reqValid))
        else $error("virtual read not zeroed");

    virt_nop_a: assert property (
        reqValid && req.mode == DAG_DIRECT && isVirt(firstHit.kind) && isVirt(tgtHit.kind) && req.destSel
        |=> !res.memWr && ptrs[$past(firstHit.pair)] == $past(selPtr))
        else $error("virtual write not dropped");

    own_load_a: assert property (
        reqValid && req.mode == DAG_DIRECT && isVirt(firstHit.kind) && !isVirt(tgtHit.kind)
        && ownLoad && tgtHit.kind == V_LOW
        |=> ptrs[$past(firstHit.pair)][7:0] == $past(req.wrData))
        else $error("own pair write stepped");

    plain_hold_a: assert property (
        reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_PLAIN
        && !isVirt(tgtHit.kind) && !isPtrReg(tgtHit.kind)
        |=> res.srcAddr == $past(selPtr) && ptrs[$past(firstHit.pair)] == $past(selPtr))
        else $error("plain operand moved pointer");

    access_high_a: assert property (
        reqValid && req.mode == DAG_DIRECT && !req.accessSel && req.fileAddr >= `DAG_ACCESS_SPLIT
        && !isVirt(firstHit.kind)
        |=> res.srcAddr == {`DAG_ACCESS_HI, $past(req.fileAddr)} && res.memRd)
        else $error("upper access bank address wrong");

    indexed_addr_a: assert property (
        reqValid && req.mode == DAG_DIRECT && extendedSet && !req.accessSel
        && req.fileAddr <= `DAG_EXT_LIMIT && !isVirt(firstHit.kind)
        |=> res.srcAddr == $past(ptrTwo) + {4'h0, $past(req.fileAddr)})
        else $error("indexed offset address wrong");

    literal_out_a: assert property (
        reqValid && req.mode == DAG_LITERAL
        |=> res.progTarget == $past(req.literal) && !res.memRd && !res.memWr)
        else $error("program target literal wrong");

    ptr_read_a: assert property (
        reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_LOW
        |=> res.ptrHit && res.ptrData == $past(selPtr[7:0]))
        else $error("pointer byte read wrong");

    move_seen_c: cover property (reqValid && req.mode == DAG_FULL_MOVE ##1 res.memWr);
    post_inc_c: cover property (reqValid && req.mode == DAG_DIRECT && firstHit.kind == V_POST_INCREMENT_OPERAND);
    virt_zero_c: cover property (res.readZero);
    indexed_c: cover property (reqValid && req.mode == DAG_DIRECT && indexedLit);
    own_load_c: cover property (reqValid && req.mode == DAG_DIRECT && ownLoad);

endmodule

/* File: tb/dag_mem_model.sv */
/*
 * behavioural data space behind the address generator: stores and counts writes.
 * assumes: registered dag_top results; wrData held from the request cycle.
 */
`timescale 1ns/100ps

module dag_mem_model import dag_pkg::*; (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire dag_res_t    res,
    input  wire logic [7:0]  wrData,
    output      int          writeCount
);
    logic [7:0] mem [0:4095];

    // pointer bytes live inside the pairs, so a pointer hit is not stored here
    always_ff @(posedge clock) begin
        if (rst) begin
            writeCount <= 0;
        end else if (res.memWr && !res.ptrHit) begin
            mem[res.dstAddr] <= wrData;
            writeCount <= writeCount + 1;
        end
    end
endmodule

/* File: tb/data_address_generation_tb.sv */
/*
 * self-checking bench for dag_top: direct, full move, literal, pointer steps and special cases.
 * assumes: one-cycle registered answer, operand blocks at 0xFEF/0xFE7/0xFDF downward.
 */
`timescale 1ns/100ps

module data_address_generation_tb import dag_pkg::*;;
    logic        clock;
    logic        rst;
    logic        reqValid;
    dag_req_t    req;
    logic [3:0]  bankSel;
    logic [7:0]  workReg;
    logic        extendedSet;
    dag_res_t    res;
    logic [11:0] ptrZero;
    logic [11:0] ptrOne;
    logic [11:0] ptrTwo;
    int          writeCount;
    int          badCount;
    int          nCompared;
    int          n;
    logic [7:0]  f;
    logic [7:0]  d;
    logic        a;
    logic [7:0]  wTab [4];

    dag_top u_dag_top (
        .clock       (clock),
        .rst         (rst),
        .reqValid    (reqValid),
        .req         (req),
        .bankSel     (bankSel),
        .workReg     (workReg),
        .extendedSet (extendedSet),
        .res         (res),
        .ptrZero     (ptrZero),
        .ptrOne      (ptrOne),
        .ptrTwo      (ptrTwo)
    );

    dag_mem_model u_dag_mem_model (
        .clock      (clock),
        .rst        (rst),
        .res        (res),
        .wrData     (req.wrData),
        .writeCount (writeCount)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic stop_test();
        if (badCount == 0 && nCompared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_addr(input string what, input logic [11:0] exp, input logic [11:0] got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_wide(input string what, input logic [19:0] exp, input logic [19:0] got);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one request, answer settled on return; a spare edge keeps reqValid from toggling twice
    task automatic send(input dag_mode_t m, input logic [7:0] fa, input logic as, input logic ds,
                        input logic [7:0] wd);
        @(posedge clock);
        #1;
        reqValid = 1'b1;
        req.mode = m;
        req.fileAddr = fa;
        req.accessSel = as;
        req.destSel = ds;
        req.wrData = wd;
        @(posedge clock);
        #1;
        reqValid = 1'b0;
    endtask

    task automatic set_ptr(input int k, input logic [11:0] v);
        send(DAG_DIRECT, 8'hEA - 8'(8 * k), 1'b0, 1'b1, {4'h0, v[11:8]});
        send(DAG_DIRECT, 8'hE9 - 8'(8 * k), 1'b0, 1'b1, v[7:0]);
    endtask

    function automatic logic [11:0] exp_direct(input logic [7:0] fa, input logic as, input logic [3:0] bk,
                                               input logic ext, input logic [11:0] p2);
        if (ext && !as && fa <= 8'h5F) return p2 + {4'h0, fa};
        if (as) return {bk, fa};
        return {(fa < 8'h80) ? 4'h0 : 4'hF, fa};
    endfunction

    initial begin
        repeat (5000) @(posedge clock);
        badCount++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        req = '0;
        bankSel = 4'h0;
        workReg = 8'h00;
        extendedSet = 1'b0;
        badCount = 0;
        nCompared = 0;
        void'($urandom(65117));
        wTab = '{8'h80, 8'h7F, 8'hFF, 8'($urandom)};
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        chk_addr("ptrZero", 12'h000, ptrZero);
        chk_bit("valid", 1'b0, res.valid);
        set_ptr(2, 12'h300);
        // fileAddr kept below the operand blocks so the draws stay plain direct accesses
        for (int i = 0; i < 40; i++) begin
            f = 8'($urandom % 217);
            a = 1'($urandom);
            d = 8'($urandom);
            bankSel = 4'($urandom);
            extendedSet = 1'($urandom);
            send(DAG_DIRECT, f, a, d[0], d);
            chk_addr("srcAddr", exp_direct(f, a, bankSel, extendedSet, 12'h300), res.srcAddr);
            chk_bit("toWork", ~d[0], res.toWork);
            chk_bit("memWr", d[0], res.memWr);
            req.fullSrc = 12'($urandom);
            req.fullDst = 12'($urandom);
            req.literal = 20'($urandom);
            send(DAG_FULL_MOVE, f, a, 1'b0, d);
            chk_addr("fullSrc", req.fullSrc, res.srcAddr);
            chk_addr("fullDst", req.fullDst, res.dstAddr);
            chk_bit("moveWr", 1'b1, res.memWr);
            send(DAG_LITERAL, f, a, 1'b0, d);
            chk_wide("progTarget", req.literal, res.progTarget);
            chk_wide("literal", {12'h000, req.literal[7:0]}, {12'h000, res.literal});
        end
        extendedSet = 1'b0;
        bankSel = 4'h5;
        send(DAG_INHERENT, 8'h00, 1'b0, 1'b0, 8'h00);
        chk_bit("inherent", 1'b1, res.valid);
        set_ptr(0, 12'h0FF);
        chk_addr("ptrZero", 12'h0FF, ptrZero);
        send(DAG_DIRECT, 8'hEE, 1'b0, 1'b0, 8'h00);
        chk_addr("post_increment_operand addr", 12'h0FF, res.srcAddr);
        chk_addr("post_increment_operand ptr", 12'h100, ptrZero);
        send(DAG_DIRECT, 8'hED, 1'b0, 1'b0, 8'h00);
        chk_addr("post_decrement_operand addr", 12'h100, res.srcAddr);
        chk_addr("post_decrement_operand ptr", 12'h0FF, ptrZero);
        send(DAG_DIRECT, 8'hEC, 1'b0, 1'b0, 8'h00);
        chk_addr("pre_increment_operand addr", 12'h100, res.srcAddr);
        chk_addr("pre_increment_operand ptr", 12'h100, ptrZero);
        bankSel = 4'hF;
        send(DAG_DIRECT, 8'hEF, 1'b1, 1'b0, 8'h00);
        chk_addr("plain addr", 12'h100, res.srcAddr);
        chk_addr("plain ptr", 12'h100, ptrZero);
        chk_bit("memRd", 1'b1, res.memRd);
        send(DAG_DIRECT, 8'hEA, 1'b0, 1'b1, 8'hAB);
        send(DAG_DIRECT, 8'hEA, 1'b0, 1'b0, 8'h00);
        chk_wide("high byte", 20'h0_000B, {12'h000, res.ptrData});
        chk_addr("high nibble", 12'hB00, ptrZero);
        set_ptr(1, 12'h3F0);
        foreach (wTab[k]) begin
            workReg = wTab[k];
            send(DAG_DIRECT, 8'hE3, 1'b0, 1'b0, 8'h00);
            chk_addr("offset addr", 12'h3F0 + {{4{wTab[k][7]}}, wTab[k]}, res.srcAddr);
            chk_addr("offset ptr", 12'h3F0, ptrOne);
        end
        set_ptr(0, 12'hFE7);
        @(posedge clock);
        #1;
        n = writeCount;
        send(DAG_DIRECT, 8'hEE, 1'b0, 1'b0, 8'h00);
        chk_bit("readZero", 1'b1, res.readZero);
        chk_bit("memRd", 1'b0, res.memRd);
        chk_addr("no step", 12'hFE7, ptrZero);
        send(DAG_DIRECT, 8'hEF, 1'b0, 1'b1, 8'h5A);
        chk_bit("memWr", 1'b0, res.memWr);
        chk_addr("ptrOne kept", 12'h3F0, ptrOne);
        @(posedge clock);
        #1;
        chk_addr("writes", 12'(n), 12'(writeCount));
        set_ptr(2, 12'hFD9);
        send(DAG_DIRECT, 8'hDD, 1'b0, 1'b1, 8'h3C);
        chk_addr("own write", 12'hF3C, ptrTwo);
        chk_bit("ptrHit", 1'b1, res.ptrHit);
        set_ptr(0, 12'hFE1);
        send(DAG_DIRECT, 8'hEF, 1'b0, 1'b1, 8'h77);
        chk_addr("other pair", 12'h377, ptrOne);
        chk_bit("readZero", 1'b0, res.readZero);
        stop_test();
    end
endmodule
